// *** src/gpis_top.sv ***
// Operation
// - select bit clear: interrupt one follows port 3 bit 3 pin.
// - select bit set: interrupt one follows OR of all port-2 inputs.
// - four read/write 8-bit pull-up registers, bit N controls pin N.
// - writing 1 to a pull-up bit disconnects that pin's pull-up.
// - a 0 bit, the reset value, connects the pull-up.
// - low nibble codes 3 to 10 give 3 ms to 10 ms delay.
// - codes 0, 1 and 11 to 15 give a 5 ms delay.
// - delay code resets to 2 (2 ms); upper nibble reads zero.
`timescale 1ns/1ps
module gpis_top #(
  parameter int MS_TICK_CYCLES = gpis_pkg::MS_TICK_CYCLES
) (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire gpis_pkg::gpis_mmr_req_t mmr_req,
  output logic [7:0]                  mmr_rdata_q,
  output logic                        mmr_rvalid_q,
  input  wire logic [7:0]             port2_pins,
  input  wire logic                   port3_bit3_pin,
  output logic                        external_interrupt_one_n_q,
  output logic [31:0]                 pin_pullup_on_q
);

  logic        ext_irq_source_select_q;
  logic        rsv7_q;
  logic [7:0]  pullup_q [4];
  logic [3:0]  p2_code_q;
  logic [gpis_pkg::TICK_CNT_W-1:0] tick_cnt_q;
  logic        ms_tick_q;
  logic        p2_qual;
  logic        p2_any;
  logic [3:0]  p2_delay_ms;
  logic        ext_irq_n_d;
  logic [7:0]  rd_mux;
  logic        wr_mcfg;
  logic        wr_p2;
  logic [3:0]  wr_pullup;
  logic [31:0] pullup_on_d;

  ////////////////////////////////////////////////////////////////////////////
  // write decode
  assign wr_mcfg      = mmr_req.wr && mmr_req.addr == gpis_pkg::OFS_MCU_CONFIG;
  assign wr_p2        = mmr_req.wr && mmr_req.addr == gpis_pkg::OFS_P2_DELAY;
  assign wr_pullup[0] = mmr_req.wr && mmr_req.addr == gpis_pkg::OFS_PULLUP0;
  assign wr_pullup[1] = mmr_req.wr && mmr_req.addr == gpis_pkg::OFS_PULLUP1;
  assign wr_pullup[2] = mmr_req.wr && mmr_req.addr == gpis_pkg::OFS_PULLUP2;
  assign wr_pullup[3] = mmr_req.wr && mmr_req.addr == gpis_pkg::OFS_PULLUP3;

  // configuration bits; revision and boot bits live elsewhere and read zero here
  always_ff @(posedge mclk) begin
    if (rst) begin
      ext_irq_source_select_q    <= gpis_pkg::MCFG_EXT_IRQ_SOURCE_SELECT_RST;
      rsv7_q    <= gpis_pkg::MCFG_RSV7_RST;
      p2_code_q <= gpis_pkg::P2_DELAY_RST;
    end else begin
      if (wr_mcfg) begin
        ext_irq_source_select_q <= mmr_req.wdata[gpis_pkg::MCFG_EXT_IRQ_SOURCE_SELECT_BIT];
        rsv7_q <= mmr_req.wdata[gpis_pkg::MCFG_RSV7_BIT];
      end
      if (wr_p2) begin
        p2_code_q <= mmr_req.wdata[3:0];
      end
    end
  end

  // pull-up control registers, all zero after reset so every pull-up is on
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 4; i++) begin
      if (rst) begin
        pullup_q[i] <= gpis_pkg::PULLUP_RST;
      end else if (wr_pullup[i]) begin
        pullup_q[i] <= mmr_req.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path: registered data, unmapped offsets answer zero
  assign rd_mux = (mmr_req.addr == gpis_pkg::OFS_MCU_CONFIG) ? {rsv7_q, ext_irq_source_select_q, 6'h00} :
                  (mmr_req.addr == gpis_pkg::OFS_PULLUP0)    ? pullup_q[0] :
                  (mmr_req.addr == gpis_pkg::OFS_PULLUP1)    ? pullup_q[1] :
                  (mmr_req.addr == gpis_pkg::OFS_PULLUP2)    ? pullup_q[2] :
                  (mmr_req.addr == gpis_pkg::OFS_PULLUP3)    ? pullup_q[3] :
                  (mmr_req.addr == gpis_pkg::OFS_P2_DELAY)   ? {4'h0, p2_code_q} :
                  8'h00;

  always_ff @(posedge mclk) begin
    if (rst) begin
      mmr_rdata_q  <= 8'h00;
      mmr_rvalid_q <= 1'b0;
    end else begin
      mmr_rdata_q  <= mmr_req.rd ? rd_mux : 8'h00;
      mmr_rvalid_q <= mmr_req.rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pad drive: a set control bit turns the pull-up off
  assign pullup_on_d = ~{pullup_q[3], pullup_q[2], pullup_q[1], pullup_q[0]};

  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_pullup_on_q <= 32'hffffffff;
    end else begin
      pin_pullup_on_q <= pullup_on_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // millisecond time base; the period is a parameter so simulation can shorten it
  always_ff @(posedge mclk) begin
    if (rst) begin
      tick_cnt_q <= '0;
      ms_tick_q  <= 1'b0;
    end else if (tick_cnt_q == gpis_pkg::TICK_CNT_W'(MS_TICK_CYCLES - 1)) begin
      tick_cnt_q <= '0;
      ms_tick_q  <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      ms_tick_q  <= 1'b0;
    end
  end

  // port-2 source: OR of the pins, qualified by the programmed delay
  assign p2_any      = |port2_pins;
  assign p2_delay_ms = gpis_pkg::gpis_delay_ms(p2_code_q);

  gpis_p2_qual u_p2_qual (
    .mclk     (mclk),
    .rst      (rst),
    .ms_tick  (ms_tick_q),
    .cond     (p2_any),
    .delay_ms (p2_delay_ms),
    .qual_q   (p2_qual)
  );

  // interrupt one is active low; the source pin passes as is, port 2 is inverted
  assign ext_irq_n_d = ext_irq_source_select_q ? !p2_qual : port3_bit3_pin;

  always_ff @(posedge mclk) begin
    if (rst) begin
      external_interrupt_one_n_q <= 1'b1;
    end else begin
      external_interrupt_one_n_q <= ext_irq_n_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_SRC_PIN: assert property (
    !ext_irq_source_select_q |=> external_interrupt_one_n_q == $past(port3_bit3_pin))
    else $error("interrupt one does not follow the port 3 pin");
  AST_SRC_PORT2: assert property (
    ext_irq_source_select_q && port2_pins == 8'h00 ##1 ext_irq_source_select_q |=> external_interrupt_one_n_q)
    else $error("interrupt one asserted with port 2 idle");
  AST_PULLUP_RW: assert property (
    wr_pullup[1] ##1 (mmr_req.rd && !mmr_req.wr && mmr_req.addr == gpis_pkg::OFS_PULLUP1)
    |=> mmr_rdata_q == $past(mmr_req.wdata, 2))
    else $error("pull-up register read back wrong");
  AST_PULLUP_OFF: assert property (
    wr_pullup[2] |=> ##1 pin_pullup_on_q[23:16] == ~$past(mmr_req.wdata, 2))
    else $error("pull-up drive does not follow control bits");
  AST_PULLUP_RESET: assert property (
    $past(rst) |=> pin_pullup_on_q == 32'hffffffff)
    else $error("pull-ups not all on after reset");
  AST_CODE_RANGE: assert property (
    p2_code_q >= gpis_pkg::P2_CODE_MIN && p2_code_q <= gpis_pkg::P2_CODE_MAX
    |-> p2_delay_ms == p2_code_q)
    else $error("delay code in range decoded wrong");
  AST_CODE_FALLBACK: assert property (
    p2_code_q < gpis_pkg::P2_DELAY_RST || p2_code_q > gpis_pkg::P2_CODE_MAX
    |-> p2_delay_ms == gpis_pkg::P2_FALLBACK_MS)
    else $error("out-of-range delay code not 5 ms");
  AST_CODE_RESET: assert property (
    $past(rst) |-> p2_code_q == gpis_pkg::P2_DELAY_RST && p2_delay_ms == gpis_pkg::P2_DELAY_RST)
    else $error("delay code not 2 after reset");
  AST_UPPER_ZERO: assert property (
    mmr_req.rd && mmr_req.addr == gpis_pkg::OFS_P2_DELAY |=> mmr_rdata_q[7:4] == 4'h0)
    else $error("delay register upper nibble not zero");

  COV_PORT2_IRQ: cover property (ext_irq_source_select_q ##1 $fell(external_interrupt_one_n_q));
  COV_PIN_IRQ: cover property (!ext_irq_source_select_q ##1 $fell(external_interrupt_one_n_q));
  COV_PULLUP_OFF: cover property (wr_pullup[0] && mmr_req.wdata == 8'hff);
  COV_DELAY_WR: cover property (wr_p2 && mmr_req.wdata[3:0] == 4'ha);

endmodule

// *** src/gpis_pkg.sv ***
package gpis_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing: one millisecond time base derived from the 100 MHz core clock
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          TIME_BASE_MS   = 1;
  localparam int          MS_TICK_CYCLES = TIME_BASE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int          TICK_CNT_W     = 17;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets on the memory-mapped register port
  localparam int          ADDR_W         = 3;
  localparam logic [2:0]  OFS_MCU_CONFIG = 3'h0;
  localparam logic [2:0]  OFS_PULLUP0    = 3'h1;
  localparam logic [2:0]  OFS_PULLUP1    = 3'h2;
  localparam logic [2:0]  OFS_PULLUP2    = 3'h3;
  localparam logic [2:0]  OFS_PULLUP3    = 3'h4;
  localparam logic [2:0]  OFS_P2_DELAY   = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // field positions and reset values
  localparam int          MCFG_EXT_IRQ_SOURCE_SELECT_BIT  = 6;
  localparam int          MCFG_RSV7_BIT  = 7;
  localparam logic        MCFG_EXT_IRQ_SOURCE_SELECT_RST  = 1'h0;
  localparam logic        MCFG_RSV7_RST  = 1'h0;
  localparam logic [7:0]  PULLUP_RST     = 8'h00;
  localparam logic [3:0]  P2_DELAY_RST   = 4'h2;
  localparam logic [3:0]  P2_CODE_MIN    = 4'h3;
  localparam logic [3:0]  P2_CODE_MAX    = 4'ha;
  localparam logic [3:0]  P2_FALLBACK_MS = 4'h5;
  localparam logic [3:0]  P2_CNT_MAX     = 4'hf;

  ////////////////////////////////////////////////////////////////////////////
  // one register access from the core
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } gpis_mmr_req_t;

  // delay code to milliseconds
  function automatic logic [3:0] gpis_delay_ms(input logic [3:0] code);
    logic [3:0] ms;
    ms = P2_FALLBACK_MS;
    if (code == P2_DELAY_RST) begin
      ms = code;
    end else if (code >= P2_CODE_MIN && code <= P2_CODE_MAX) begin
      ms = code;
    end
    return ms;
  endfunction

endpackage

// *** src/gpis_p2_qual.sv ***
`timescale 1ns/1ps
// counts millisecond ticks while the port-2 condition holds
module gpis_p2_qual (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ms_tick,
  input  wire logic       cond,
  input  wire logic [3:0] delay_ms,
  output logic            qual_q
);

  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic       qual_d;

  // saturating count so a long-held condition never wraps back to idle
  assign cnt_d  = !cond ? 4'h0 :
                  (ms_tick && cnt_q != gpis_pkg::P2_CNT_MAX) ? cnt_q + 4'h1 : cnt_q;
  assign qual_d = cond && (cnt_d >= delay_ms);

  // the first tick may come early, so the real wait is delay-1 to delay ms
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_q  <= 4'h0;
      qual_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      qual_q <= qual_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_QUAL_NEEDS_DELAY: assert property (@(posedge mclk) disable iff (rst)
    qual_q |-> cnt_q >= $past(delay_ms))
    else $error("port-2 interrupt raised before its delay ran out");
  AST_QUAL_DROPS: assert property (@(posedge mclk) disable iff (rst)
    !cond |=> !qual_q && cnt_q == 4'h0)
    else $error("port-2 interrupt held without its condition");

endmodule

// *** test/gpis_pin_model.sv ***
`timescale 1ns/1ps
// circuitry on the port pins: drives a pin when enabled, else pull-up or a floating level
module gpis_pin_model (
  input  wire logic        mclk,
  input  wire logic [31:0] pull_on,
  input  wire logic [8:0]  drv_en,
  input  wire logic [8:0]  drv_val,
  output logic      [7:0]  port2_pins,
  output logic             port3_bit3_pin
);
  logic       flt_q = 1'b0;
  logic [8:0] pull;
  logic [8:0] lvl;

  ////////////////////////////////////////////////////////////////////////////
  // a floating pin flips every cycle so a stale level never passes for a real one
  always @(posedge mclk) begin
    flt_q <= ~flt_q;
  end

  // bit 8 is port 3 bit 3, bits 7:0 are port 2
  assign pull = {pull_on[27], pull_on[23:16]};
  assign lvl  = (drv_en & drv_val) | (~drv_en & pull) | (~drv_en & ~pull & {9{flt_q}});
  assign port2_pins     = lvl[7:0];
  assign port3_bit3_pin = lvl[8];
endmodule

// *** test/tb_gpio_pullup_and_external_interrupt_one_select.sv ***
`timescale 1ns/1ps
module tb_gpio_pullup_and_external_interrupt_one_select;
  localparam int T = 4;
  logic                    mclk;
  logic                    rst;
  gpis_pkg::gpis_mmr_req_t mmr_req;
  logic [7:0]              rdata;
  logic                    rvalid;
  logic [7:0]              port2_pins;
  logic                    port3_bit3_pin;
  logic                    irq_n;
  logic [31:0]             pull_on;
  logic [8:0]              drv_en;
  logic [8:0]              drv_val;
  int                      num_errors;
  int                      samples_checked;
  int                      n;
  logic [3:0]              ms;

  gpis_top #(.MS_TICK_CYCLES(T)) u_gpis_top (.mclk(mclk), .rst(rst), .mmr_req(mmr_req),
    .mmr_rdata_q(rdata), .mmr_rvalid_q(rvalid), .port2_pins(port2_pins),
    .port3_bit3_pin(port3_bit3_pin), .external_interrupt_one_n_q(irq_n),
    .pin_pullup_on_q(pull_on));
  gpis_pin_model u_gpis_pin_model (.mclk(mclk), .pull_on(pull_on), .drv_en(drv_en),
    .drv_val(drv_val), .port2_pins(port2_pins), .port3_bit3_pin(port3_bit3_pin));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one-cycle strobes; idle cycle after each so a strobe is never reassigned in one step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    mmr_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    mmr_req <= '0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    mmr_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    mmr_req <= '0;
    #1;
    chk("rvalid", {31'h0, rvalid}, 32'h1);
    chk("rdata", {24'h0, rdata}, {24'h0, exp});
    @(posedge mclk);
  endtask

  // counts cycles until interrupt one reaches lvl; a spent bound ends the run
  task automatic wait_irq(input logic lvl, input int lim);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (irq_n !== lvl && n < lim);
    if (irq_n !== lvl) begin
      chk("irq wait", {31'h0, irq_n}, {31'h0, lvl});
      results();
    end
    @(posedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    rst = 1'b1;
    mmr_req = '0;
    drv_en = 9'h1ff;
    drv_val = 9'h100;
    num_errors = 0;
    samples_checked = 0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk("pullups after reset", pull_on, 32'hffffffff);
    rd(3'h0, 8'h00);
    rd(3'h5, 8'h02);
    for (int p = 0; p < 4; p++) begin
      rd(3'(p + 1), 8'h00);
      wr(3'(p + 1), 8'h5a + 8'(p));
    end
    // unmapped writes must not alias onto any pull-up register
    wr(3'h6, 8'hff);
    wr(3'h7, 8'hff);
    for (int p = 0; p < 4; p++) begin
      rd(3'(p + 1), 8'h5a + 8'(p));
      chk("pullup pins", {24'h0, pull_on[8*p +: 8]}, {24'h0, ~(8'h5a + 8'(p))});
    end
    // write then read on the very next edge, with no idle cycle between
    mmr_req <= '{wr: 1'b1, rd: 1'b0, addr: 3'h2, wdata: 8'h3c};
    @(posedge mclk);
    rd(3'h2, 8'h3c);
    rd(3'h6, 8'h00);
    wr(3'h5, 8'hff);
    rd(3'h5, 8'h0f);
    // select clear: port 2 high is ignored, port 3 pin passes through
    drv_val <= 9'h1ff;
    repeat (60) @(posedge mclk);
    chk("irq p2 ignored", {31'h0, irq_n}, 32'h1);
    drv_val <= 9'h000;
    wait_irq(1'b0, 4);
    chk("p3 latency", {31'h0, n <= 2}, 32'h1);
    repeat (40000) @(posedge mclk);
    chk("irq held", {31'h0, irq_n}, 32'h1 ^ 32'h1);
    drv_val <= 9'h100;
    wait_irq(1'b1, 4);
    // select set: a short port-2 pulse with port 3 low must not fire
    wr(3'h0, 8'h40);
    rd(3'h0, 8'h40);
    wr(3'h5, 8'h0a);
    drv_val <= 9'h001;
    repeat (5 * T) @(posedge mclk);
    drv_val <= 9'h000;
    repeat (60) @(posedge mclk);
    chk("short pulse", {31'h0, irq_n}, 32'h1);
    for (int c = 0; c < 16; c++) begin
      ms = (c >= 2 && c <= 10) ? 4'(c) : 4'h5;
      wr(3'h5, 8'(c));
      drv_val <= 9'h001 << (c % 8);
      wait_irq(1'b0, 60);
      chk("delay low", {31'h0, n >= (ms - 1) * T}, 32'h1);
      chk("delay high", {31'h0, n <= ms * T + 3}, 32'h1);
      drv_val <= 9'h000;
      wait_irq(1'b1, 4);
    end
    // released port-2 pins: pull-ups on raise the OR, pull-ups off leave them floating
    wr(3'h3, 8'h00);
    drv_en <= 9'h000;
    wait_irq(1'b0, 60);
    wr(3'h3, 8'hff);
    wait_irq(1'b1, 8);
    repeat (30) @(posedge mclk);
    chk("floating port 2", {31'h0, irq_n}, 32'h1);
    results();
  end
endmodule
